/* pin_sync3.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync3 #(
	parameter int W = 1
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level_out
);

	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	wire [W-1:0] agree_mask = ~(stage2 ^ stage3);
	wire [W-1:0] next_level = (stage2 & agree_mask) | (level_out & ~agree_mask);

	// Only stage2 reads stage1; the filter looks at stage2 and stage3
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			level_out <= '0;
		end else begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
			level_out <= next_level;
		end
	end

endmodule

/* test_transmitter_sequence_timers.sv */
// Self-checking bench for the transmitter sequence timers
`timescale 1ns/1ns
module test_transmitter_sequence_timers;
	typedef struct packed {
		logic [5:0] a;
		logic [31:0] w;
		logic [31:0] e;
	} row_t;
	localparam int TICK = 2;
	logic mclk_in, rst_n_in, wr_in, rd_in, hv_cmd, irq, fil, hv, blower;
	logic nv_load;
	logic [19:0] vswr;
	logic [5:0] addr_in;
	logic [31:0] wdata_in, rdata, d;
	logic [2:0] press, sel;
	logic [15:0] plate_extra, screen_ma, plate_i, normal_i, screen_i, grid_i;
	tx_seq_pkg::panel_t panel;
	tx_seq_pkg::lamps_t lamps;
	tx_seq_pkg::set_bank_t settings;
	int mismatches, n_tests, n;
	row_t rows [8];
	tx_stage_panel_model far (.hv_cmd_in(hv_cmd), .press_in(press),
		.sel_in(sel), .plate_extra_in(plate_extra), .screen_ma_in(screen_ma),
		.hv_on_in(hv), .panel_out(panel), .plate_out(plate_i),
		.normal_out(normal_i), .screen_out(screen_i), .grid_out(grid_i));
	transmitter_sequence_timers #(.TICK_CYCLES(TICK)) uut (.mclk_in,
		.rst_n_in, .panel_in(panel), .plate_current_in(plate_i),
		.plate_normal_in(normal_i), .screen_current_in(screen_i),
		.grid_current_in(grid_i), .nv_load_in(nv_load),
		.nv_settings_in(tx_seq_pkg::SET_DEF), .addr_in, .wdata_in, .wr_in,
		.rd_in, .rdata_out(rdata), .irq_out(irq), .filament_on_out(fil),
		.plate_hv_on_out(hv), .blower_on_out(blower), .lamps_out(lamps),
		.settings_out(settings), .vswr_threshold_out(vswr));
	initial begin
		mclk_in = 0;
		forever #50 mclk_in = ~mclk_in;
	end
	task check(input logic [159:0] seen, input logic [159:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task bus_wr(input logic [5:0] a, input logic [31:0] w);
		@(posedge mclk_in);
		addr_in <= a;
		wdata_in <= w;
		wr_in <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
		#1;
	endtask
	task bus_rd(input logic [5:0] a, output logic [31:0] v);
		@(posedge mclk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		#1 v = rdata;
	endtask
	// Switches are held long enough to pass the input filter
	task pulse(input logic [2:0] s, input logic [2:0] p);
		@(posedge mclk_in) sel <= s;
		repeat (8) @(posedge mclk_in);
		press <= p;
		repeat (8) @(posedge mclk_in);
		press <= 3'h0;
		repeat (8) @(posedge mclk_in);
		#1;
	endtask
	task wait_out(input int which, input logic v, input int lim,
		output int cnt);
		logic [2:0] o;
		cnt = 0;
		o = {blower, fil, hv};
		while (o[which] !== v && cnt < lim) begin
			@(posedge mclk_in);
			#1 cnt++;
			o = {blower, fil, hv};
		end
	endtask
	task test_done;
		$display("Comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge mclk_in);
		mismatches++;
		test_done;
	end
	////////////////////////////////////////
	initial begin
		rows = '{'{6'h00, 32'h0, 32'h2710}, '{6'h04, 32'h0, 32'h3E8},
			'{6'h08, 32'h0, 32'h64}, '{6'h0C, 32'h0, 32'h7530},
			'{6'h10, 32'h1F4, 32'h14A}, '{6'h14, 32'h258, 32'h258},
			'{6'h18, 32'h0, 32'hF}, '{6'h1C, 32'h64, 32'h3C}};
		{rst_n_in, wr_in, rd_in, hv_cmd, press, sel, nv_load} = 0;
		{addr_in, wdata_in, plate_extra} = 0;
		screen_ma = 16'h00C8;
		mismatches = 0;
		n_tests = 0;
		repeat (12) @(posedge mclk_in);
		#1 check({fil, hv, blower, irq, lamps, rdata}, 0);
		check(settings, tx_seq_pkg::SET_DEF);
		@(posedge mclk_in) rst_n_in <= 1'b1;
		foreach (rows[i]) begin
			bus_wr(rows[i].a, rows[i].w);
			bus_rd(rows[i].a, d);
			check(d, rows[i].e);
			check(settings[i], rows[i].e[19:0]);
		end
		check(vswr, 20'h0000F);
		bus_rd(6'h30, d);
		check(d, 0);
		bus_rd(6'h28, d);
		check(d, 0);
		pulse(3'h4, 3'b010);
		check(settings[4], 20'h14A);
		pulse(3'h4, 3'b001);
		check(settings[4], 20'h145);
		pulse(3'h5, 3'b010);
		check(settings[5], 20'h262);
		@(posedge mclk_in) hv_cmd <= 1'b1;
		wait_out(0, 1'b1, 25000, n);
		check(n >= 10000 * TICK && n < 25000, 1);
		check(irq, 0);
		bus_wr(6'h24, 32'h8);
		check(irq, 1);
		bus_wr(6'h28, 32'h8);
		check(irq, 0);
		bus_rd(6'h20, d);
		check(d, 32'h20);
		@(posedge mclk_in) plate_extra <= 16'h0263;
		wait_out(0, 1'b0, 10, n);
		@(posedge mclk_in) plate_extra <= 16'h0;
		repeat (2) @(posedge mclk_in);
		#1 check(lamps, 4'h9);
		wait_out(0, 1'b1, 400, n);
		check(n >= 190 && n < 400, 1);
		pulse(3'h5, 3'b100);
		check(lamps, 4'h0);
		@(posedge mclk_in) screen_ma <= 16'h0146;
		wait_out(0, 1'b0, 10, n);
		@(posedge mclk_in) screen_ma <= 16'h00C8;
		repeat (2) @(posedge mclk_in);
		#1 check(lamps, 4'h5);
		wait_out(0, 1'b1, 400, n);
		pulse(3'h5, 3'b100);
		@(posedge mclk_in) hv_cmd <= 1'b0;
		wait_out(1, 1'b0, 20, n);
		check(fil, 0);
		repeat (200) @(posedge mclk_in);
		hv_cmd <= 1'b1;
		wait_out(0, 1'b1, 40, n);
		check(n < 40, 1);
		@(posedge mclk_in) hv_cmd <= 1'b0;
		wait_out(1, 1'b0, 20, n);
		wait_out(2, 1'b0, 70000, n);
		check(n >= 30000 * TICK - 10 && n <= 30000 * TICK + 10, 1);
		@(posedge mclk_in) nv_load <= 1'b1;
		@(posedge mclk_in) nv_load <= 1'b0;
		#1 check(settings, tx_seq_pkg::SET_DEF);
		test_done;
	end
endmodule

/* transmitter_sequence_timers.sv */
// Filament, plate and blower sequencing with adjustable trip settings
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ns
module transmitter_sequence_timers #(
	parameter int TICK_CYCLES = tx_seq_pkg::TICK_CYCLES,
	parameter int CUR_W = 16
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire tx_seq_pkg::panel_t panel_in,
	input wire logic [CUR_W-1:0] plate_current_in,
	input wire logic [CUR_W-1:0] plate_normal_in,
	input wire logic [CUR_W-1:0] screen_current_in,
	input wire logic [CUR_W-1:0] grid_current_in,
	input wire logic nv_load_in,
	input wire tx_seq_pkg::set_bank_t nv_settings_in,
	input wire logic [tx_seq_pkg::ADDR_W-1:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	output logic irq_out,
	output logic filament_on_out,
	output logic plate_hv_on_out,
	output logic blower_on_out,
	output tx_seq_pkg::lamps_t lamps_out,
	output tx_seq_pkg::set_bank_t settings_out,
	output logic [tx_seq_pkg::SET_W-1:0] vswr_threshold_out
);

	localparam int SW = tx_seq_pkg::SET_W;
	localparam int TW = $clog2(TICK_CYCLES);

	initial begin
		if (TICK_CYCLES < 2) begin
			$error("TICK_CYCLES must be at least 2");
		end
		if (CUR_W < 8 || CUR_W > SW - 1) begin
			$error("CUR_W must lie between 8 and 19");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Panel inputs

	tx_seq_pkg::panel_t panel;
	tx_seq_pkg::panel_t panel_prev;

	pin_sync3 #(
		.W($bits(tx_seq_pkg::panel_t))
	) u_panel_sync (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.pin_in(panel_in),
		.level_out(panel)
	);

	wire up_edge = panel.step_up & ~panel_prev.step_up;
	wire down_edge = panel.step_down & ~panel_prev.step_down;
	// Both levers at once is a bounce, not an action
	wire step_evt = up_edge ^ down_edge;
	wire ovl_reset_evt = panel.overload_reset & ~panel_prev.overload_reset;
	wire [2:0] sel = panel.parameter_select_switch;
	wire any_req = panel.filament_req | panel.hv_req;

	////////////////////////////////////////////////////////////////////////
	// Millisecond tick

	logic [TW-1:0] prescale;
	wire tick_wrap = (prescale == TW'(TICK_CYCLES - 1));
	wire tick = tick_wrap;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prescale <= '0;
		end else begin
			prescale <= tick_wrap ? '0 : prescale + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Adjustable settings

	function automatic logic [SW-1:0] clamp_set(input logic [2:0] c,
			input logic [SW-1:0] v);
		if (v < tx_seq_pkg::SET_MIN[c]) begin
			return tx_seq_pkg::SET_MIN[c];
		end
		if (v > tx_seq_pkg::SET_MAX[c]) begin
			return tx_seq_pkg::SET_MAX[c];
		end
		return v;
	endfunction

	function automatic logic [SW-1:0] step_set(input logic [2:0] c,
			input logic up, input logic [SW-1:0] v);
		logic [SW:0] sum;
		logic [SW:0] floor_sum;
		sum = {1'b0, v} + {1'b0, tx_seq_pkg::SET_STEP[c]};
		floor_sum = {1'b0, tx_seq_pkg::SET_MIN[c]} +
			{1'b0, tx_seq_pkg::SET_STEP[c]};
		if (up) begin
			if (sum > {1'b0, tx_seq_pkg::SET_MAX[c]}) begin
				return tx_seq_pkg::SET_MAX[c];
			end
			return sum[SW-1:0];
		end
		if ({1'b0, v} < floor_sum) begin
			return tx_seq_pkg::SET_MIN[c];
		end
		return v - tx_seq_pkg::SET_STEP[c];
	endfunction

	tx_seq_pkg::set_bank_t setting;
	tx_seq_pkg::set_bank_t next_setting;

	wire set_hit = (addr_in[5] == 1'b0) && (addr_in[1:0] == 2'h0);
	wire [2:0] bus_code = addr_in[4:2];
	wire set_wr = wr_in & set_hit;
	wire [SW-1:0] stepped = step_set(sel, up_edge, setting[sel]);

	// Restore beats bus write beats panel step
	always_comb begin
		next_setting = setting;
		if (nv_load_in) begin
			for (int i = 0; i < tx_seq_pkg::NUM_SET; i++) begin
				next_setting[i] = clamp_set(3'(i), nv_settings_in[i]);
			end
		end else if (set_wr) begin
			next_setting[bus_code] = clamp_set(bus_code, wdata_in[SW-1:0]);
		end else if (step_evt) begin
			next_setting[sel] = stepped;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			setting <= tx_seq_pkg::SET_DEF;
			panel_prev <= '0;
		end else begin
			setting <= next_setting;
			panel_prev <= panel;
		end
	end

	assign settings_out = setting;
	assign vswr_threshold_out = setting[tx_seq_pkg::CODE_VSWR];

	////////////////////////////////////////////////////////////////////////
	// Overload comparators

	wire [SW-1:0] plate_limit = SW'(plate_normal_in) +
		setting[tx_seq_pkg::CODE_PLATE];
	wire plate_over = SW'(plate_current_in) > plate_limit;
	wire screen_over = SW'(screen_current_in) >
		setting[tx_seq_pkg::CODE_SCREEN];
	wire grid_over = SW'(grid_current_in) >
		setting[tx_seq_pkg::CODE_GRID];

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	tx_seq_pkg::seq_state_t state;
	tx_seq_pkg::seq_state_t next_state;
	logic [SW-1:0] phase_ms;
	logic [SW-1:0] phase_lim;
	logic [SW-1:0] off_ms;
	logic [SW-1:0] cool_lim;
	logic [SW-1:0] defeat_lim;
	logic [SW-1:0] next_phase_lim;

	wire in_hv = (state == tx_seq_pkg::ST_HV);
	wire trip = in_hv & (plate_over | screen_over | grid_over);
	wire phase_done = (phase_ms >= phase_lim);
	wire filament_warm = (off_ms <= defeat_lim);
	wire off_sat = (off_ms == tx_seq_pkg::OFF_TIME_RST);
	// Leaving off starts the blower with the filament, never a cycle late
	wire blower_run = (state != tx_seq_pkg::ST_OFF) ||
		(next_state != tx_seq_pkg::ST_OFF) || (off_ms < cool_lim);

	always_comb begin
		next_state = state;
		next_phase_lim = phase_lim;
		unique case (state)
			tx_seq_pkg::ST_OFF: begin
				if (any_req && filament_warm) begin
					next_state = panel.hv_req ? tx_seq_pkg::ST_HV :
						tx_seq_pkg::ST_STANDBY;
				end else if (any_req) begin
					next_state = tx_seq_pkg::ST_WARMUP;
					next_phase_lim = setting[tx_seq_pkg::CODE_WARMUP];
				end
			end
			tx_seq_pkg::ST_WARMUP: begin
				if (!any_req) begin
					next_state = tx_seq_pkg::ST_OFF;
				end else if (phase_done) begin
					next_state = tx_seq_pkg::ST_STANDBY;
				end
			end
			tx_seq_pkg::ST_STANDBY: begin
				if (!any_req) begin
					next_state = tx_seq_pkg::ST_OFF;
				end else if (panel.hv_req) begin
					next_state = tx_seq_pkg::ST_HV;
				end
			end
			tx_seq_pkg::ST_HV: begin
				if (trip) begin
					next_state = tx_seq_pkg::ST_RECYCLE;
					next_phase_lim = setting[tx_seq_pkg::CODE_RECYCLE];
				end else if (!panel.hv_req) begin
					next_state = panel.filament_req ? tx_seq_pkg::ST_STANDBY :
						tx_seq_pkg::ST_OFF;
				end
			end
			tx_seq_pkg::ST_RECYCLE: begin
				if (!any_req) begin
					next_state = tx_seq_pkg::ST_OFF;
				end else if (phase_done) begin
					next_state = panel.hv_req ? tx_seq_pkg::ST_HV :
						tx_seq_pkg::ST_STANDBY;
				end
			end
			default: begin
				next_state = tx_seq_pkg::ST_OFF;
			end
		endcase
	end

	wire leave_off = (state == tx_seq_pkg::ST_OFF) &&
		(next_state != tx_seq_pkg::ST_OFF);
	wire enter_off = (state != tx_seq_pkg::ST_OFF) &&
		(next_state == tx_seq_pkg::ST_OFF);
	wire phase_restart = (next_state != state);

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= tx_seq_pkg::ST_OFF;
			phase_ms <= '0;
			phase_lim <= '0;
		end else begin
			state <= next_state;
			phase_lim <= next_phase_lim;
			if (phase_restart) begin
				phase_ms <= '0;
			end else if (tick && !phase_done) begin
				phase_ms <= phase_ms + 1'b1;
			end
		end
	end

	// Off time doubles as cool-down timer and defeat timer
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			off_ms <= tx_seq_pkg::OFF_TIME_RST;
			cool_lim <= '0;
			defeat_lim <= '0;
		end else if (enter_off) begin
			off_ms <= '0;
			cool_lim <= setting[tx_seq_pkg::CODE_COOL];
			defeat_lim <= setting[tx_seq_pkg::CODE_DEFEAT];
		end else if (state == tx_seq_pkg::ST_OFF && tick && !off_sat) begin
			off_ms <= off_ms + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs and indicator lamps

	logic blower_prev;
	tx_seq_pkg::lamps_t next_lamps;

	// A trip in the same cycle as a reset press keeps the lamp lit
	always_comb begin
		next_lamps = lamps_out;
		if (ovl_reset_evt) begin
			next_lamps = '0;
		end
		if (trip) begin
			next_lamps.overload_reset = 1'b1;
		end
		if (in_hv && plate_over) begin
			next_lamps.plate = 1'b1;
		end
		if (in_hv && screen_over) begin
			next_lamps.screen = 1'b1;
		end
		if (in_hv && grid_over) begin
			next_lamps.grid = 1'b1;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lamps_out <= '0;
			filament_on_out <= 1'b0;
			plate_hv_on_out <= 1'b0;
			blower_on_out <= 1'b0;
			blower_prev <= 1'b0;
		end else begin
			lamps_out <= next_lamps;
			filament_on_out <= (next_state != tx_seq_pkg::ST_OFF);
			plate_hv_on_out <= (next_state == tx_seq_pkg::ST_HV);
			blower_on_out <= blower_run;
			blower_prev <= blower_run;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts

	logic [tx_seq_pkg::IRQ_W-1:0] irq_status;
	logic [tx_seq_pkg::IRQ_W-1:0] irq_enable;
	logic [tx_seq_pkg::IRQ_W-1:0] events;

	always_comb begin
		events = '0;
		events[tx_seq_pkg::IRQ_PLATE] = in_hv & plate_over;
		events[tx_seq_pkg::IRQ_SCREEN] = in_hv & screen_over;
		events[tx_seq_pkg::IRQ_GRID] = in_hv & grid_over;
		events[tx_seq_pkg::IRQ_HV_ON] = ~in_hv &
			(next_state == tx_seq_pkg::ST_HV);
		events[tx_seq_pkg::IRQ_BLOWER_OFF] = blower_prev & ~blower_run;
		events[tx_seq_pkg::IRQ_WARM_DONE] =
			(state == tx_seq_pkg::ST_WARMUP) &&
			(next_state == tx_seq_pkg::ST_STANDBY);
	end

	wire clr_wr = wr_in && (addr_in == tx_seq_pkg::OFS_IRQ_CLEAR);
	wire en_wr = wr_in && (addr_in == tx_seq_pkg::OFS_IRQ_ENABLE);
	wire [tx_seq_pkg::IRQ_W-1:0] clr_mask = clr_wr ?
		wdata_in[tx_seq_pkg::IRQ_W-1:0] : '0;
	wire [tx_seq_pkg::IRQ_W-1:0] next_status = (irq_status & ~clr_mask) |
		events;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_status <= '0;
			irq_enable <= tx_seq_pkg::IRQ_ENABLE_RST;
		end else begin
			irq_status <= next_status;
			if (en_wr) begin
				irq_enable <= wdata_in[tx_seq_pkg::IRQ_W-1:0];
			end
		end
	end

	assign irq_out = |(irq_status & irq_enable);

	////////////////////////////////////////////////////////////////////////
	// Register read port

	wire [31:0] rd_mux =
		set_hit ? 32'(setting[bus_code]) :
		(addr_in == tx_seq_pkg::OFS_IRQ_STATUS) ? 32'(irq_status) :
		(addr_in == tx_seq_pkg::OFS_IRQ_ENABLE) ? 32'(irq_enable) :
		(addr_in == tx_seq_pkg::OFS_STATE) ?
			{25'h0000000, lamps_out, 3'(state)} :
		32'h00000000;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_out <= 32'h00000000;
		end else begin
			rdata_out <= rd_in ? rd_mux : 32'h00000000;
		end
	end

endmodule

/* tx_seq_pkg.sv */
// Constants, setting tables and types for the transmitter sequence timers
package tx_seq_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and tick prescaler
	localparam int CLK_PERIOD_NS = 100;
	localparam int TICK_PERIOD_MS = 1;
	localparam int TICK_CYCLES = (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	// Setting codes of the parameter selector
	localparam logic [2:0] CODE_WARMUP = 3'h0;
	localparam logic [2:0] CODE_DEFEAT = 3'h1;
	localparam logic [2:0] CODE_RECYCLE = 3'h2;
	localparam logic [2:0] CODE_COOL = 3'h3;
	localparam logic [2:0] CODE_SCREEN = 3'h4;
	localparam logic [2:0] CODE_PLATE = 3'h5;
	localparam logic [2:0] CODE_VSWR = 3'h6;
	localparam logic [2:0] CODE_GRID = 3'h7;

	localparam int SET_W = 20;
	localparam int NUM_SET = 8;
	typedef logic [0:NUM_SET-1][SET_W-1:0] set_bank_t;

	// Times in ms, currents in mA, VSWR in tenths of the ratio.
	// Order: warm-up, defeat, recycle, cool-down, screen, plate, VSWR, grid
	localparam set_bank_t SET_MIN = {
		20'h02710, 20'h003E8, 20'h00064, 20'h07530,
		20'h000E6, 20'h00064, 20'h0000F, 20'h00028};
	localparam set_bank_t SET_MAX = {
		20'h41EB0, 20'h03A98, 20'h03A98, 20'h41EB0,
		20'h0014A, 20'h002EE, 20'h0001E, 20'h0003C};
	localparam set_bank_t SET_DEF = {
		20'h02710, 20'h00BB8, 20'h007D0, 20'h07530,
		20'h00118, 20'h001F4, 20'h0001C, 20'h00032};
	localparam set_bank_t SET_STEP = {
		20'h003E8, 20'h003E8, 20'h003E8, 20'h003E8,
		20'h00005, 20'h0000A, 20'h00001, 20'h00001};

	////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFS_SETTING = 6'h00;
	localparam logic [5:0] OFS_IRQ_STATUS = 6'h20;
	localparam logic [5:0] OFS_IRQ_ENABLE = 6'h24;
	localparam logic [5:0] OFS_IRQ_CLEAR = 6'h28;
	localparam logic [5:0] OFS_STATE = 6'h2C;

	// Interrupt bit positions
	localparam int IRQ_W = 6;
	localparam int IRQ_PLATE = 0;
	localparam int IRQ_SCREEN = 1;
	localparam int IRQ_GRID = 2;
	localparam int IRQ_HV_ON = 3;
	localparam int IRQ_BLOWER_OFF = 4;
	localparam int IRQ_WARM_DONE = 5;
	localparam logic [IRQ_W-1:0] IRQ_ENABLE_RST = 6'h00;

	// Off time after reset: saturated, so a cold start always warms up
	localparam logic [SET_W-1:0] OFF_TIME_RST = 20'hFFFFF;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [2:0] {
		ST_OFF, ST_WARMUP, ST_STANDBY, ST_HV, ST_RECYCLE
	} seq_state_t;

	typedef struct packed {
		logic filament_req;
		logic hv_req;
		logic overload_reset;
		logic step_up;
		logic step_down;
		logic [2:0] parameter_select_switch;
	} panel_t;

	typedef struct packed {
		logic plate;
		logic screen;
		logic grid;
		logic overload_reset;
	} lamps_t;

endpackage

/* tx_seq_timers_monitor.sv */
// Checker for the transmitter sequence timers, bound to the top module
`timescale 1ns/1ns
module tx_seq_timers_monitor #(
	parameter int TICK_CYCLES = 10,
	parameter int CUR_W = 16
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic [CUR_W-1:0] plate_current_in,
	input wire logic [CUR_W-1:0] plate_normal_in,
	input wire logic [CUR_W-1:0] screen_current_in,
	input wire logic nv_load_in,
	input wire logic [tx_seq_pkg::ADDR_W-1:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic filament_on_out,
	input wire logic plate_hv_on_out,
	input wire logic blower_on_out,
	input wire tx_seq_pkg::lamps_t lamps_out,
	input wire tx_seq_pkg::set_bank_t settings_out
);
	// First tick may fall right after the trip, so allow one tick less
	localparam int REC_MIN = 99 * TICK_CYCLES;
	int off_cnt;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			off_cnt <= 0;
		else if (plate_hv_on_out)
			off_cnt <= 0;
		else if (off_cnt < 1000000)
			off_cnt <= off_cnt + 1;
	end
	////////////////////////////////////////
	AST_HV_FIL: assert property (plate_hv_on_out |-> filament_on_out)
		else $error("plate voltage on without filament");
	AST_FIL_BLOW: assert property (filament_on_out |-> blower_on_out)
		else $error("filament on without blower");
	AST_COOL_RUN: assert property ($fell(filament_on_out) |=>
		blower_on_out [*8]) else $error("blower stopped at filament off");
	AST_WR_PLATE: assert property (wr_in && !nv_load_in &&
		addr_in == 6'h14 && wdata_in >= 32'h64 && wdata_in <= 32'h2EE
		|=> settings_out[5] == $past(wdata_in[19:0]))
		else $error("plate threshold write lost");
	AST_SCR_RANGE: assert property (settings_out[4] >= 20'hE6 &&
		settings_out[4] <= 20'h14A) else $error("screen setting range");
	AST_REC_RANGE: assert property (settings_out[2] >= 20'h64 &&
		settings_out[2] <= 20'h3A98) else $error("recycle setting range");
	AST_PLATE_TRIP: assert property (plate_hv_on_out &&
		$past(plate_hv_on_out) &&
		plate_current_in > plate_normal_in + settings_out[5] |-> ##[1:4]
		(lamps_out.plate && lamps_out.overload_reset && !plate_hv_on_out))
		else $error("plate overload not tripped");
	AST_SCR_TRIP: assert property (plate_hv_on_out &&
		$past(plate_hv_on_out) && screen_current_in > settings_out[4]
		|-> ##[1:4] (lamps_out.screen && !plate_hv_on_out))
		else $error("screen overload not tripped");
	AST_RECYCLE: assert property ($rose(plate_hv_on_out) &&
		lamps_out.overload_reset |-> off_cnt >= REC_MIN)
		else $error("recycle time too short");
	COV_HV: cover property ($rose(plate_hv_on_out));
	COV_SCR: cover property ($rose(lamps_out.screen));
	COV_COOL: cover property ($fell(blower_on_out));
endmodule

bind transmitter_sequence_timers tx_seq_timers_monitor #(
	.TICK_CYCLES(TICK_CYCLES), .CUR_W(CUR_W)) mon (.mclk_in, .rst_n_in,
	.plate_current_in, .plate_normal_in, .screen_current_in, .nv_load_in,
	.addr_in, .wdata_in, .wr_in, .filament_on_out, .plate_hv_on_out,
	.blower_on_out, .lamps_out, .settings_out);

/* tx_stage_panel_model.sv */
// Front panel switches and power stage currents seen by the controller
`timescale 1ns/1ns
module tx_stage_panel_model #(
	parameter logic [15:0] NORMAL_MA = 16'h03E8
) (
	input wire logic hv_cmd_in,
	input wire logic [2:0] press_in,
	input wire logic [2:0] sel_in,
	input wire logic [15:0] plate_extra_in,
	input wire logic [15:0] screen_ma_in,
	input wire logic hv_on_in,
	output tx_seq_pkg::panel_t panel_out,
	output logic [15:0] plate_out,
	output logic [15:0] normal_out,
	output logic [15:0] screen_out,
	output logic [15:0] grid_out
);
	// Press order: overload reset, step up, step down
	assign panel_out = {1'b0, hv_cmd_in, press_in, sel_in};
	assign normal_out = NORMAL_MA;
	// Tube draws nothing while plate voltage is off
	assign plate_out = hv_on_in ? NORMAL_MA + plate_extra_in : 16'h0000;
	assign screen_out = hv_on_in ? screen_ma_in : 16'h0000;
	assign grid_out = hv_on_in ? 16'h0014 : 16'h0000;
endmodule
